// ===== core/flash_host_regs.svh
// timing constants, command sequence bytes and geometry for the sector flash host
// How it works
// - host loads all 256 bytes of a sector for every program operation not cut off by a load stall.
// - host opens every program operation with the three fixed command writes.
// - host pulses write strobe with select low and output gate high.
// - host starts each next byte load within 150 us of previous rise.
// - host holds the sector address on every byte-load falling edge; bytes in ascending order.
// - host locks a boot block with six fixed command writes and a seventh to the block address.
// - host erases the whole array with a six-write command sequence.
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// clock and pin timing
`define CLK_PERIOD_NS   10
`define T_WP_NS         100
`define T_WPH_NS        50
`define T_AS_NS         40
`define T_ACC_NS        150
`define SYNC_LAT_CYC    5
`define LOAD_GAP_US     150
`define GAP_GUARD_CYC   64
`define PROG_TIME_MS    20

// geometry
`define SECTOR_BYTES    256
`define ADDR_W          18
`define SECTOR_LSB      8

// command sequence lengths
`define PROG_CMD_LEN    3
`define ERASE_CMD_LEN   6
`define LOCK_CMD_LEN    7

// command addresses and bytes, plain defaults
`define CMD_ADDR_A      18'h05555
`define CMD_ADDR_B      18'h02aaa
`define CMD_BYTE_UNLK1  8'haa
`define CMD_BYTE_UNLK2  8'h55
`define CMD_BYTE_PROG   8'ha0
`define CMD_BYTE_EXT    8'h80
`define CMD_BYTE_ERASE  8'h10
`define CMD_BYTE_LOCK   8'h40
`define CMD_BYTE_LOCKD  8'h00

`endif

// ===== core/flash_host_pkg.sv
// types shared by the sector flash host
package flash_host_pkg;

   // user operations
   typedef enum logic [1:0] {
      OP_READ  = 2'h0,
      OP_PROG  = 2'h1,
      OP_ERASE = 2'h2,
      OP_LOCK  = 2'h3
   } op_t;

   // one-hot controller states
   typedef enum logic [8:0] {
      ST_IDLE     = 9'h001,
      ST_WR_SETUP = 9'h002,
      ST_WR_LOW   = 9'h004,
      ST_WR_HIGH  = 9'h008,
      ST_LOAD     = 9'h010,
      ST_RD_ACC   = 9'h020,
      ST_POLL_RD  = 9'h040,
      ST_POLL_GAP = 9'h080,
      ST_FINISH   = 9'h100
   } state_t;

endpackage : flash_host_pkg

// ===== core/flash_pin_sync.sv
// three-stage input synchroniser for the flash data lines
`timescale 1ns/1ns
module flash_pin_sync (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [7:0] pin_in,
   output logic      [7:0] pin_q
);

   // ===================================================
   // per-bit three-flop chain plus an output flop, output follows once 2nd and 3rd agree
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_bit
         logic s1_reg, s2_reg, s3_reg, q_reg;
         logic q_next;

         // accept a change only when the last two stages match
         always_comb begin
            q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
         end

         // register the chain
         always_ff @(posedge mclk) begin
            if (rst) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               q_reg  <= 1'b0;
            end else begin
               s1_reg <= pin_in[gi];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               q_reg  <= q_next;
            end
         end

         assign pin_q[gi] = q_reg;
      end
   endgenerate

endmodule : flash_pin_sync

// ===== core/flash_host.sv
// host controller that reads, programs, erases and locks the sector flash over its pins
`timescale 1ns/1ns
`include "flash_host_regs.svh"
module flash_host #(
   parameter int LOAD_GAP_CYC     = (`LOAD_GAP_US * 1000) / `CLK_PERIOD_NS,
   parameter int PROG_TIMEOUT_CYC = (`PROG_TIME_MS * 1000000) / `CLK_PERIOD_NS
) (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire logic                 cmd_valid,
   output logic                      cmd_ready,
   input  wire flash_host_pkg::op_t  cmd_op,
   input  wire logic [17:0]          cmd_addr,
   input  wire logic                 ld_valid,
   output logic                      ld_ready,
   input  wire logic [7:0]           ld_data,
   output logic                      rd_valid,
   output logic [7:0]                rd_data,
   output logic                      done,
   output logic                      err,
   output logic [17:0]               address_lines,
   output logic                      ce_n,
   output logic                      oe_n,
   output logic                      we_n,
   input  wire logic [7:0]           data_lines_in,
   output logic [7:0]                data_lines_out,
   output logic                      data_lines_oe
);

   // ===================================================
   // cycle counts
   localparam logic [7:0]  WP_CYC  = 8'((`T_WP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
   localparam logic [7:0]  WPH_CYC = 8'((`T_WPH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
   localparam logic [7:0]  AS_CYC  = 8'((`T_AS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
   localparam logic [7:0]  RD_CYC  =
      8'((`T_ACC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + `SYNC_LAT_CYC);
   localparam logic [15:0] GAP_ABORT = 16'(LOAD_GAP_CYC - `GAP_GUARD_CYC);
   localparam logic [8:0]  PROG_LEN  = 9'(`PROG_CMD_LEN);
   localparam logic [8:0]  PROG_ALL  = 9'(`PROG_CMD_LEN + `SECTOR_BYTES);

   flash_host_pkg::state_t state_reg, state_next;
   flash_host_pkg::op_t    op_reg, op_next;
   logic [8:0]  step_reg, step_next;
   logic [7:0]  cnt_reg, cnt_next;
   logic [15:0] gap_reg, gap_next;
   logic        gap_run_reg, gap_run_next;
   logic [21:0] ptmr_reg, ptmr_next;
   logic [17:0] tgt_reg, tgt_next;
   logic [17:0] addr_reg, addr_next;
   logic [7:0]  dout_reg, dout_next;
   logic        doe_reg, doe_next;
   logic        ce_n_reg, ce_n_next;
   logic        oe_n_reg, oe_n_next;
   logic        we_n_reg, we_n_next;
   logic        bit6_reg, bit6_next;
   logic        first_reg, first_next;
   logic [7:0]  rd_data_reg, rd_data_next;
   logic        err_reg, err_next;
   logic [7:0]  sync_q;
   logic [8:0]  seq_len;
   logic [8:0]  step_off;
   logic        byte_step;
   logic [25:0] cmd_word;

   // ===================================================
   // data line input synchroniser
   flash_pin_sync u_sync (
      .mclk   (mclk),
      .rst    (rst),
      .pin_in (data_lines_in),
      .pin_q  (sync_q)
   );

   // ===================================================
   // command word for a step: {address, data}
   function automatic logic [25:0] seq_word(flash_host_pkg::op_t op, logic [8:0] st,
                                            logic [17:0] tgt);
      logic [25:0] w;
      w = {`CMD_ADDR_A, `CMD_BYTE_UNLK1};
      case (st)
         9'h000: w = {`CMD_ADDR_A, `CMD_BYTE_UNLK1};
         9'h001: w = {`CMD_ADDR_B, `CMD_BYTE_UNLK2};
         9'h002: w = {`CMD_ADDR_A, (op == flash_host_pkg::OP_PROG) ?
                                    `CMD_BYTE_PROG : `CMD_BYTE_EXT};
         9'h003: w = {`CMD_ADDR_A, `CMD_BYTE_UNLK1};
         9'h004: w = {`CMD_ADDR_B, `CMD_BYTE_UNLK2};
         9'h005: w = {`CMD_ADDR_A, (op == flash_host_pkg::OP_ERASE) ?
                                    `CMD_BYTE_ERASE : `CMD_BYTE_LOCK};
         default: w = {tgt, `CMD_BYTE_LOCKD};
      endcase
      return w;
   endfunction : seq_word

   // sequence length and the byte phase of a program operation
   always_comb begin
      case (op_reg)
         flash_host_pkg::OP_PROG:  seq_len = PROG_ALL;
         flash_host_pkg::OP_ERASE: seq_len = 9'(`ERASE_CMD_LEN);
         flash_host_pkg::OP_LOCK:  seq_len = 9'(`LOCK_CMD_LEN);
         default:                  seq_len = 9'h000;
      endcase
      step_off  = step_reg - PROG_LEN;
      byte_step = (op_reg == flash_host_pkg::OP_PROG) && (step_reg >= PROG_LEN);
      cmd_word  = seq_word(op_reg, step_reg, tgt_reg);
   end

   // ===================================================
   // controller next-state logic
   always_comb begin
      state_next   = state_reg;
      op_next      = op_reg;
      step_next    = step_reg;
      cnt_next     = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : cnt_reg;
      gap_next     = gap_run_reg ? gap_reg + 16'h0001 : 16'h0000;
      gap_run_next = gap_run_reg;
      ptmr_next    = ptmr_reg;
      tgt_next     = tgt_reg;
      addr_next    = addr_reg;
      dout_next    = dout_reg;
      doe_next     = doe_reg;
      ce_n_next    = ce_n_reg;
      oe_n_next    = oe_n_reg;
      we_n_next    = we_n_reg;
      bit6_next    = bit6_reg;
      first_next   = first_reg;
      rd_data_next = rd_data_reg;
      err_next     = err_reg;
      case (state_reg)
         flash_host_pkg::ST_IDLE: begin
            if (cmd_valid) begin
               op_next    = cmd_op;
               tgt_next   = cmd_addr;
               step_next  = 9'h000;
               err_next   = 1'b0;
               ptmr_next  = 22'h000000;
               ce_n_next  = 1'b0;
               if (cmd_op == flash_host_pkg::OP_READ) begin
                  addr_next  = cmd_addr;
                  oe_n_next  = 1'b0;
                  cnt_next   = RD_CYC;
                  state_next = flash_host_pkg::ST_RD_ACC;
               end else begin
                  // every program opens with the fixed command writes
                  addr_next  = `CMD_ADDR_A;
                  dout_next  = `CMD_BYTE_UNLK1;
                  doe_next   = 1'b1;
                  cnt_next   = AS_CYC;
                  state_next = flash_host_pkg::ST_WR_SETUP;
               end
            end
         end
         flash_host_pkg::ST_WR_SETUP: begin
            if (cnt_reg == 8'h00) begin
               // strobe low only with select low and gate high
               we_n_next    = 1'b0;
               gap_run_next = 1'b0;
               cnt_next     = WP_CYC;
               state_next   = flash_host_pkg::ST_WR_LOW;
            end
         end
         flash_host_pkg::ST_WR_LOW: begin
            if (cnt_reg == 8'h00) begin
               we_n_next    = 1'b1;
               gap_run_next = 1'b1;
               cnt_next     = WPH_CYC;
               step_next    = step_reg + 9'h001;
               state_next   = flash_host_pkg::ST_WR_HIGH;
            end
         end
         flash_host_pkg::ST_WR_HIGH: begin
            if (cnt_reg == 8'h00) begin
               if (step_reg == seq_len) begin
                  // all writes given: release the bus and start polling
                  gap_run_next = 1'b0;
                  doe_next     = 1'b0;
                  ce_n_next    = 1'b1;
                  first_next   = 1'b1;
                  addr_next    = (op_reg == flash_host_pkg::OP_LOCK) ? tgt_reg : addr_reg;
                  cnt_next     = AS_CYC;
                  state_next   = flash_host_pkg::ST_POLL_GAP;
               end else if (byte_step) begin
                  state_next = flash_host_pkg::ST_LOAD;
               end else begin
                  addr_next  = cmd_word[25:8];
                  dout_next  = cmd_word[7:0];
                  cnt_next   = AS_CYC;
                  state_next = flash_host_pkg::ST_WR_SETUP;
               end
            end
         end
         flash_host_pkg::ST_LOAD: begin
            if (ld_valid) begin
               // sector bits fixed, byte index from the step
               addr_next  = {tgt_reg[17:8], step_off[7:0]};
               dout_next  = ld_data;
               cnt_next   = AS_CYC;
               state_next = flash_host_pkg::ST_WR_SETUP;
            end
         end
         flash_host_pkg::ST_RD_ACC: begin
            if (cnt_reg == 8'h00) begin
               rd_data_next = sync_q;
               ce_n_next    = 1'b1;
               oe_n_next    = 1'b1;
               cnt_next     = AS_CYC;
               state_next   = flash_host_pkg::ST_FINISH;
            end
         end
         flash_host_pkg::ST_POLL_RD: begin
            ptmr_next = ptmr_reg + 22'h000001;
            if (cnt_reg == 8'h00) begin
               ce_n_next  = 1'b1;
               oe_n_next  = 1'b1;
               bit6_next  = sync_q[6];
               first_next = 1'b0;
               cnt_next   = AS_CYC;
               // toggle bit stopped: cycle over
               if (!first_reg && (sync_q[6] == bit6_reg))
                  state_next = flash_host_pkg::ST_FINISH;
               else
                  state_next = flash_host_pkg::ST_POLL_GAP;
            end
         end
         flash_host_pkg::ST_POLL_GAP: begin
            ptmr_next = ptmr_reg + 22'h000001;
            if (cnt_reg == 8'h00) begin
               if (ptmr_reg >= 22'(PROG_TIMEOUT_CYC)) begin
                  err_next   = 1'b1;
                  state_next = flash_host_pkg::ST_FINISH;
               end else begin
                  ce_n_next  = 1'b0;
                  oe_n_next  = 1'b0;
                  cnt_next   = RD_CYC;
                  state_next = flash_host_pkg::ST_POLL_RD;
               end
            end
         end
         flash_host_pkg::ST_FINISH: begin
            if (cnt_reg == 8'h00)
               state_next = flash_host_pkg::ST_IDLE;
         end
         default: state_next = flash_host_pkg::ST_IDLE;
      endcase
      // a stalled load is cut off before the device window closes
      if (gap_run_reg && (gap_reg >= GAP_ABORT) &&
          (state_reg == flash_host_pkg::ST_LOAD)) begin
         gap_run_next = 1'b0;
         err_next     = 1'b1;
         doe_next     = 1'b0;
         ce_n_next    = 1'b1;
         first_next   = 1'b1;
         cnt_next     = AS_CYC;
         state_next   = flash_host_pkg::ST_POLL_GAP;
      end
   end

   // controller registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg   <= flash_host_pkg::ST_IDLE;
         op_reg      <= flash_host_pkg::OP_READ;
         step_reg    <= 9'h000;
         cnt_reg     <= 8'h00;
         gap_reg     <= 16'h0000;
         gap_run_reg <= 1'b0;
         ptmr_reg    <= 22'h000000;
         tgt_reg     <= 18'h00000;
         addr_reg    <= 18'h00000;
         dout_reg    <= 8'h00;
         doe_reg     <= 1'b0;
         ce_n_reg    <= 1'b1;
         oe_n_reg    <= 1'b1;
         we_n_reg    <= 1'b1;
         bit6_reg    <= 1'b0;
         first_reg   <= 1'b1;
         rd_data_reg <= 8'h00;
         err_reg     <= 1'b0;
      end else begin
         state_reg   <= state_next;
         op_reg      <= op_next;
         step_reg    <= step_next;
         cnt_reg     <= cnt_next;
         gap_reg     <= gap_next;
         gap_run_reg <= gap_run_next;
         ptmr_reg    <= ptmr_next;
         tgt_reg     <= tgt_next;
         addr_reg    <= addr_next;
         dout_reg    <= dout_next;
         doe_reg     <= doe_next;
         ce_n_reg    <= ce_n_next;
         oe_n_reg    <= oe_n_next;
         we_n_reg    <= we_n_next;
         bit6_reg    <= bit6_next;
         first_reg   <= first_next;
         rd_data_reg <= rd_data_next;
         err_reg     <= err_next;
      end
   end

   // ===================================================
   // outputs
   assign cmd_ready      = (state_reg == flash_host_pkg::ST_IDLE);
   assign ld_ready       = (state_reg == flash_host_pkg::ST_LOAD);
   assign done           = (state_reg == flash_host_pkg::ST_FINISH) && (cnt_reg == 8'h00);
   assign rd_valid       = done && (op_reg == flash_host_pkg::OP_READ);
   assign rd_data        = rd_data_reg;
   assign err            = err_reg;
   assign address_lines  = addr_reg;
   assign ce_n           = ce_n_reg;
   assign oe_n           = oe_n_reg;
   assign we_n           = we_n_reg;
   assign data_lines_out = dout_reg;
   assign data_lines_oe  = doe_reg;

   // ===================================================
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_strobe_frame;
      (!ce_n && oe_n && data_lines_oe)[*8];
   endsequence
   sequence s_left_writes;
      (state_reg == flash_host_pkg::ST_POLL_GAP) &&
      ($past(state_reg) == flash_host_pkg::ST_WR_HIGH);
   endsequence

   property p_full_sector;
      s_left_writes ##0 (op_reg == flash_host_pkg::OP_PROG) |-> step_reg == PROG_ALL;
   endproperty
   a_full_sector: assert property (p_full_sector) else $error("sector left short");

   property p_cmd_first;
      ld_ready |-> (op_reg == flash_host_pkg::OP_PROG) && (step_reg >= PROG_LEN);
   endproperty
   a_cmd_first: assert property (p_cmd_first) else $error("byte load before commands");

   property p_strobe_frame;
      $fell(we_n) |-> s_strobe_frame;
   endproperty
   a_strobe_frame: assert property (p_strobe_frame) else $error("bad write strobe frame");

   property p_no_contention;
      data_lines_oe |-> oe_n;
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("drive while gate low");

   property p_gap_bound;
      gap_run_reg |-> gap_reg < 16'(LOAD_GAP_CYC);
   endproperty
   a_gap_bound: assert property (p_gap_bound) else $error("load gap too long");

   property p_sector_hold;
      $fell(we_n) && byte_step |-> address_lines[17:8] == tgt_reg[17:8];
   endproperty
   a_sector_hold: assert property (p_sector_hold) else $error("sector address moved");

   property p_lock_len;
      s_left_writes ##0 (op_reg == flash_host_pkg::OP_LOCK) |-> step_reg == 9'(`LOCK_CMD_LEN);
   endproperty
   a_lock_len: assert property (p_lock_len) else $error("lock sequence length");

   property p_erase_len;
      s_left_writes ##0 (op_reg == flash_host_pkg::OP_ERASE) |-> step_reg == 9'(`ERASE_CMD_LEN);
   endproperty
   a_erase_len: assert property (p_erase_len) else $error("erase sequence length");

endmodule : flash_host

// ===== verification/flash_dev_model.sv
// behavioural model of the sector flash device on the host's pins
`timescale 1ns/1ns
`include "flash_host_regs.svh"
module flash_dev_model #(
   parameter int GAP_NS  = 2000,
   parameter int PROG_NS = 20000
) (
   input  wire logic [17:0] address_lines,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [7:0]  data_lines_out,
   output logic      [7:0]  data_lines_in
);
   // ==========================================
   // array, latches and sequencing state
   logic [7:0]   mem [1 << `ADDR_W];
   logic [7:0]   lat [256];
   logic [255:0] lat_ok;
   logic [17:0]  a_cap;
   logic [9:0]   sect;
   logic [7:0]   last_d = 8'h00;
   logic         osc = 1'b0, wr_on = 1'b0, loading = 1'b0, tog = 1'b0;
   logic         lock_lo = 1'b0, lock_hi = 1'b0;
   int           gap = 0, busy = 0, step = 0, load_cnt = 0, last_cnt = 0;
   time          t_fall = 0, t_chg = 0;

   initial forever #7 osc = ~osc;
   // array starts erased
   initial begin
      data_lines_in = 8'h00;
      for (int i = 0; i < (1 << `ADDR_W); i++) mem[i] = 8'hff;
   end

   task automatic take_write(input logic [17:0] a, input logic [7:0] d);
      logic ok;
      ok = ((step == 0 || step == 3) && a == `CMD_ADDR_A && d == `CMD_BYTE_UNLK1) ||
           ((step == 1 || step == 4) && a == `CMD_ADDR_B && d == `CMD_BYTE_UNLK2) ||
           (step == 2 && a == `CMD_ADDR_A && (d == `CMD_BYTE_PROG || d == `CMD_BYTE_EXT)) ||
           (step == 5 && a == `CMD_ADDR_A && (d == `CMD_BYTE_ERASE || d == `CMD_BYTE_LOCK)) ||
           (step == 6 && d == `CMD_BYTE_LOCKD);
      if (busy > 0) begin
         step = 0;   // loads ignored while programming
      end else if (loading) begin
         lat[a[7:0]] = d;
         lat_ok[a[7:0]] = 1'b1;
         sect = a[17:8];
         last_d = d;
         load_cnt++;
      end else if (!ok) begin
         step = 0;   // timer runs, nothing stored
         busy = PROG_NS / 14;
      end else if (step == 2 && d == `CMD_BYTE_PROG) begin
         step = 0;
         loading = 1'b1;
         lat_ok = '0;
         load_cnt = 0;
      end else if (step == 5 && d == `CMD_BYTE_ERASE) begin
         step = 0;
         busy = PROG_NS / 14;
         if (!(lock_lo || lock_hi)) begin
            for (int i = 0; i < (1 << `ADDR_W); i++) mem[i] = 8'hff;
         end
      end else if (step == 6) begin
         step = 0;
         busy = PROG_NS / 14;
         lock_lo = lock_lo | (a < 18'h02000);
         lock_hi = lock_hi | (a >= 18'h3e000);
      end else begin
         step++;
      end
   endtask : take_write

   // address on the later falling edge, only with gate high
   always @(negedge we_n or negedge ce_n) begin
      if (!we_n && !ce_n && oe_n) begin
         a_cap = address_lines;
         t_fall = $time;
         wr_on = 1'b1;
         gap = 0;
      end
   end

   // data on the earlier rising edge, short pulses dropped
   always @(posedge we_n or posedge ce_n) begin
      if (wr_on && $time - t_fall >= 15) take_write(a_cap, data_lines_out);
      wr_on = 1'b0;
   end

   always @(address_lines or ce_n or oe_n) t_chg = $time;

   // status bit flips at each read start while busy
   always @(negedge oe_n or negedge ce_n) begin
      if (!ce_n && !oe_n && (busy > 0 || loading)) tog = ~tog;
   end

   // window timeout, then write the whole sector, unloaded bytes as 5a
   always @(posedge osc) begin
      if (loading && !wr_on) gap++;
      if (loading && gap > GAP_NS / 14) begin
         loading = 1'b0;
         last_cnt = load_cnt;
         busy = PROG_NS / 14;
         if (!(lock_lo && sect < 10'h020) && !(lock_hi && sect >= 10'h3e0)) begin
            for (int i = 0; i < 256; i++) mem[{sect, 8'(i)}] = lat_ok[i] ? lat[i] : 8'h5a;
         end
      end else if (busy > 0) begin
         busy--;
      end
      // released or unsettled lines keep changing
      // settle one oscillator step early so data stands within the access time
      if (ce_n || oe_n || !we_n || $time - t_chg < `T_ACC_NS - 14) begin
         data_lines_in <= ~data_lines_in;
      end else if (busy > 0 || loading) begin
         data_lines_in <= {~last_d[7], tog, 6'h2a};
      end else begin
         data_lines_in <= mem[address_lines];
      end
   end
endmodule : flash_dev_model

// ===== verification/test_flash_host.sv
// self-checking testbench for the sector flash host controller
`timescale 1ns/1ns
module test_flash_host;
   // ==========================================
   // signals
   logic                mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, ld_valid = 1'b0;
   flash_host_pkg::op_t cmd_op = flash_host_pkg::OP_READ;
   logic [17:0]         cmd_addr = 18'h00000, address_lines;
   logic [7:0]          ld_data = 8'h00, seed = 8'h00, rd_data, data_lines_in, data_lines_out;
   logic [7:0]          got_rd;
   logic                cmd_ready, ld_ready, rd_valid, done, err, ce_n, oe_n, we_n;
   logic                data_lines_oe, got_rv, got_err;
   int                  num_errors = 0, samples_checked = 0, taken = 0;

   flash_host #(.LOAD_GAP_CYC(200), .PROG_TIMEOUT_CYC(5000)) flash_host_i (
      .mclk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .ld_valid, .ld_ready, .ld_data,
      .rd_valid, .rd_data, .done, .err, .address_lines, .ce_n, .oe_n, .we_n,
      .data_lines_in, .data_lines_out, .data_lines_oe
   );
   flash_dev_model #(.GAP_NS(2000), .PROG_NS(20000)) flash_dev_model_i (
      .address_lines, .ce_n, .oe_n, .we_n, .data_lines_out, .data_lines_in
   );

   initial forever #5 mclk = ~mclk;

   // ==========================================
   // shared tasks
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic end_sim();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   // issue one operation and wait for its completion pulse
   task automatic run_op(input flash_host_pkg::op_t op, input logic [17:0] a);
      int n;
      @(negedge mclk);
      cmd_op = op;
      cmd_addr = a;
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_ready !== 1'b0 && n < 10) begin
         @(negedge mclk);
         n++;
      end
      cmd_valid = 1'b0;
      while (done !== 1'b1 && n < 20000) begin
         @(negedge mclk);
         n++;
      end
      got_rv = rd_valid;
      got_rd = rd_data;
      @(negedge mclk);
      got_err = err;
      if (n >= 20000) check("completion", 8'h01, 8'h00);
   endtask : run_op

   task automatic read_exp(input logic [17:0] a, input logic [7:0] exp);
      run_op(flash_host_pkg::OP_READ, a);
      check("read valid", 8'h01, {7'h00, got_rv});
      check("read data", exp, got_rd);
   endtask : read_exp

   // program a sector whose byte k carries k xor sd
   task automatic prog(input logic [9:0] s, input logic [7:0] sd);
      @(negedge mclk);
      seed = sd;
      taken = 0;
      ld_valid = 1'b1;
      run_op(flash_host_pkg::OP_PROG, {s, 8'h00});
      ld_valid = 1'b0;
      check("bytes loaded", 8'hff, 8'(flash_dev_model_i.last_cnt - 1));
      check("load abort flag", 8'h00, {7'h00, got_err});
   endtask : prog

   // byte feeder and pin qualifier monitor
   always @(posedge mclk) if (ld_valid && ld_ready) taken <= taken + 1;
   always @(negedge mclk) ld_data <= 8'(taken) ^ seed;
   always @(negedge mclk) begin
      if (!rst && (we_n === 1'b0 || oe_n === 1'b0))
         check("pin qualifiers", (we_n === 1'b0) ? 8'h03 : 8'h00,
               {5'h00, ce_n, oe_n, data_lines_oe});
   end

   // ==========================================
   // scenarios
   task automatic read_blank();
      read_exp(18'h00100, 8'hff);
   endtask : read_blank

   task automatic sector_program();
      prog(10'h012, 8'h3c);
      read_exp(18'h01200, 8'h3c);
      read_exp(18'h0124d, 8'h71);
      read_exp(18'h012ff, 8'hc3);
   endtask : sector_program

   task automatic sector_rewrite();
      prog(10'h012, 8'ha5);
      read_exp(18'h01210, 8'hb5);
   endtask : sector_rewrite

   task automatic chip_erase();
      run_op(flash_host_pkg::OP_ERASE, 18'h00000);
      read_exp(18'h01210, 8'hff);
   endtask : chip_erase

   task automatic boot_lock();
      prog(10'h012, 8'h0f);
      run_op(flash_host_pkg::OP_LOCK, 18'h00000);
      run_op(flash_host_pkg::OP_ERASE, 18'h00000);
      read_exp(18'h01220, 8'h2f);
      prog(10'h000, 8'h77);
      read_exp(18'h00005, 8'hff);
      prog(10'h3ff, 8'h11);
      read_exp(18'h3fffe, 8'hef);
   endtask : boot_lock

   task automatic load_stall();
      @(negedge mclk);
      seed = 8'h00;
      taken = 0;
      ld_valid = 1'b1;
      fork
         run_op(flash_host_pkg::OP_PROG, 18'h10000);
         begin
            while (taken < 10) @(negedge mclk);
            ld_valid = 1'b0;
         end
      join
      check("stall abort flag", 8'h01, {7'h00, got_err});
      read_exp(18'h10003, 8'h03);
      check("flag after next op", 8'h00, {7'h00, got_err});
   endtask : load_stall

   // ==========================================
   // main sequence and watchdog
   initial begin
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      read_blank();
      sector_program();
      sector_rewrite();
      chip_erase();
      boot_lock();
      load_stall();
      end_sim();
   end

   initial begin
      #900_000;
      num_errors++;
      end_sim();
   end
endmodule : test_flash_host
